//--- loop_gain_ctrl.sv
// digital voltage-loop compensator with steady-state gain reduction
`timescale 1ns/1ns
`default_nettype none
module loop_gain_ctrl #(
	parameter int ERR_W = 16
) (
	input wire logic i_core_clk,
	input wire logic i_rst,
	input wire logic [2:0] i_first_config_strap,
	input wire logic i_cycle_strobe,
	input wire logic signed [ERR_W-1:0] i_error,
	input wire loop_gain_pkg::cmd_t i_cmd,
	output logic [31:0] o_rd_data,
	output logic o_rd_valid,
	output logic o_cmd_nack,
	output logic signed [15:0] o_pw_correction,
	output logic o_pw_valid,
	output logic [15:0] o_applied_gain,
	output logic o_gain_reduced
);
	////////////////////////////////////////////////////////////////////
	// helpers

	// fractional multiply by an 8-bit gain, result scaled down by 2^8
	function automatic logic signed [32:0] mul_frac(
		input logic signed [32:0] a, input logic [7:0] k);
		logic signed [41:0] p;
		p = a * $signed({1'b0, k});
		mul_frac = p[32+loop_gain_pkg::FRAC_SHIFT:loop_gain_pkg::FRAC_SHIFT];
	endfunction

	// clamp to the 16-bit pulse-width correction range
	function automatic logic signed [15:0] sat16(input logic signed [32:0] a);
		if (a > 33'sh0_0000_7fff)
			sat16 = 16'sh7fff;
		else if (a < -33'sh0_0000_8000)
			sat16 = -16'sh8000;
		else
			sat16 = a[15:0];
	endfunction

	////////////////////////////////////////////////////////////////////
	// strap synchroniser: three stages, value counts once 2 and 3 agree

	logic [2:0] strap_s1_reg, strap_s2_reg, strap_s3_reg;
	logic strap_done_reg, strap_done_next;
	always_ff @(posedge i_core_clk) begin
		strap_s1_reg <= i_first_config_strap;
		strap_s2_reg <= strap_s1_reg;
		strap_s3_reg <= strap_s2_reg;
	end

	////////////////////////////////////////////////////////////////////
	// configuration registers, written by the two commands and, once after reset, by the strap loader

	loop_gain_pkg::loop_cfg_t cfg_reg, cfg_next;
	loop_gain_pkg::reduce_cfg_t red_reg, red_next;
	logic [31:0] rd_data_reg, rd_data_next;
	logic rd_valid_reg, rd_valid_next;
	logic nack_reg, nack_next;
	logic strap_load;

	// the strap is taken once after reset unless software got there first
	assign strap_load = !strap_done_reg && (strap_s2_reg == strap_s3_reg);

	always_comb begin
		cfg_next = cfg_reg;
		red_next = red_reg;
		strap_done_next = strap_done_reg;
		rd_data_next = rd_data_reg;
		rd_valid_next = 1'b0;
		nack_next = 1'b0;
		if (strap_load) begin
			cfg_next.gain = loop_gain_pkg::strap_gain(strap_s3_reg); // [R2]
			strap_done_next = 1'b1;
		end
		if (i_cmd.valid) begin
			case (i_cmd.code)
			loop_gain_pkg::CMD_LOOP_GAIN_CONFIG: begin
				if (i_cmd.write) begin
					cfg_next = i_cmd.data; // [R6]
					strap_done_next = 1'b1;
				end else begin
					rd_data_next = cfg_reg;
					rd_valid_next = 1'b1;
				end
			end
			loop_gain_pkg::CMD_LOOP_GAIN_REDUCTION_CONFIG: begin
				if (i_cmd.write) begin
					red_next = i_cmd.data[15:0]; // [R6]
					red_next.rsvd = 2'h0;
				end else begin
					rd_data_next = {16'h0000, red_reg};
					rd_valid_next = 1'b1;
				end
			end
			default: begin
				nack_next = 1'b1;
			end
			endcase
		end
	end

	// reset leaves the gain for the strap loader to fill
	always_ff @(posedge i_core_clk) begin
		if (i_rst) begin
			cfg_reg <= {loop_gain_pkg::INT_GAIN_RST,
				loop_gain_pkg::RES_GAIN_RST, 16'h0000};
			red_reg <= loop_gain_pkg::REDUCTION_CFG_RST;
			strap_done_reg <= 1'b0;
			rd_data_reg <= 32'h0000_0000;
			rd_valid_reg <= 1'b0;
			nack_reg <= 1'b0;
		end else begin
			cfg_reg <= cfg_next;
			red_reg <= red_next;
			strap_done_reg <= strap_done_next;
			rd_data_reg <= rd_data_next;
			rd_valid_reg <= rd_valid_next;
			nack_reg <= nack_next;
		end
	end

	////////////////////////////////////////////////////////////////////
	// steady-state gain reducer

	loop_gain_pkg::gain_state_t state_reg, state_next;
	logic [7:0] quiet_cnt_reg, quiet_cnt_next;
	logic [15:0] err_abs;
	logic err_low;
	logic [15:0] gain_eff;

	// magnitude fits 16 bits unsigned even for the most negative error
	assign err_abs = i_error[ERR_W-1] ? 16'(-i_error) : 16'(i_error);
	assign err_low = err_abs < {4'h0, red_reg.thr}; // [R7]

	// division only while the current error is still low, so a large
	// error sees full gain in the very cycle it appears
	always_comb begin
		if (state_reg == loop_gain_pkg::GS_REDUCED && err_low)
			gain_eff = cfg_reg.gain >> ({1'b0, red_reg.div_sel} + 3'h1); // [R8]
		else
			gain_eff = cfg_reg.gain; // [R9]
	end

	always_comb begin
		state_next = state_reg;
		quiet_cnt_next = quiet_cnt_reg;
		if (i_cycle_strobe) begin
			case (state_reg)
			loop_gain_pkg::GS_FULL: begin
				if (err_low) begin
					state_next = loop_gain_pkg::GS_QUIET;
					quiet_cnt_next = 8'h01;
				end
			end
			loop_gain_pkg::GS_QUIET: begin
				if (!err_low) begin
					state_next = loop_gain_pkg::GS_FULL; // [R9]
					quiet_cnt_next = 8'h00;
				end else if (quiet_cnt_reg ==
					loop_gain_pkg::QUIET_CYCLES - 8'h01) begin
					state_next = loop_gain_pkg::GS_REDUCED; // [R10]
				end else begin
					quiet_cnt_next = quiet_cnt_reg + 8'h01;
				end
			end
			loop_gain_pkg::GS_REDUCED: begin
				if (!err_low) begin
					state_next = loop_gain_pkg::GS_FULL; // [R9]
					quiet_cnt_next = 8'h00;
				end
			end
			default: begin
				state_next = loop_gain_pkg::GS_FULL;
				quiet_cnt_next = 8'h00;
			end
			endcase
		end
	end

	always_ff @(posedge i_core_clk) begin
		if (i_rst) begin
			state_reg <= loop_gain_pkg::GS_FULL;
			quiet_cnt_reg <= 8'h00;
		end else begin
			state_reg <= state_next;
			quiet_cnt_reg <= quiet_cnt_next;
		end
	end

	////////////////////////////////////////////////////////////////////
	// compensator datapath, one update per switching cycle

	logic signed [32:0] err_ext, p_full, p_term, i_term, r_term;
	logic signed [32:0] integ_reg, integ_next;
	logic signed [32:0] resid_src_reg, resid_src_next;
	logic signed [15:0] pw_reg, pw_next;
	logic pw_valid_reg, pw_valid_next;
	logic [15:0] app_gain_reg, app_gain_next;
	logic reduced_reg, reduced_next;

	assign err_ext = 33'(i_error);
	assign p_full = err_ext * $signed({1'b0, gain_eff});
	assign p_term = p_full >>> loop_gain_pkg::FRAC_SHIFT; // [R1]
	assign i_term = mul_frac(err_ext, cfg_reg.int_gain); // [R3]
	// last cycle's gain term, so damping cannot touch the first peak
	assign r_term = mul_frac(resid_src_reg, cfg_reg.res_gain); // [R4] [R5]

	// integrator wraps silently; the output clamp hides large windup
	always_comb begin
		integ_next = integ_reg;
		resid_src_next = resid_src_reg;
		pw_next = pw_reg;
		pw_valid_next = 1'b0;
		app_gain_next = app_gain_reg;
		reduced_next = reduced_reg;
		if (i_cycle_strobe) begin
			integ_next = integ_reg + i_term; // [R3]
			resid_src_next = p_term; // [R5]
			pw_next = sat16(p_term + integ_reg + i_term - r_term); // [R1] [R4]
			pw_valid_next = 1'b1;
			app_gain_next = gain_eff;
			// taken from the state, so a zero gain still reports division
			reduced_next = (state_reg == loop_gain_pkg::GS_REDUCED &&
				err_low); // [R8]
		end
	end

	always_ff @(posedge i_core_clk) begin
		if (i_rst) begin
			integ_reg <= 33'sh0;
			resid_src_reg <= 33'sh0;
			pw_reg <= 16'sh0000;
			pw_valid_reg <= 1'b0;
			app_gain_reg <= 16'h0000;
			reduced_reg <= 1'b0;
		end else begin
			integ_reg <= integ_next;
			resid_src_reg <= resid_src_next;
			pw_reg <= pw_next;
			pw_valid_reg <= pw_valid_next;
			app_gain_reg <= app_gain_next;
			reduced_reg <= reduced_next;
		end
	end

	assign o_rd_data = rd_data_reg;
	assign o_rd_valid = rd_valid_reg;
	assign o_cmd_nack = nack_reg;
	assign o_pw_correction = pw_reg;
	assign o_pw_valid = pw_valid_reg;
	assign o_applied_gain = app_gain_reg;
	assign o_gain_reduced = reduced_reg;

	////////////////////////////////////////////////////////////////////
	// checks

	default clocking cb @(posedge i_core_clk); endclocking
	default disable iff (i_rst);

	sequence pulse_s;
		o_pw_valid ##1 !o_pw_valid;
	endsequence
	sequence strobe_alone_s;
		i_cycle_strobe ##1 !i_cycle_strobe;
	endsequence
	sequence strobe_gap_s;
		i_cycle_strobe ##1 (!i_cycle_strobe)[*2];
	endsequence

	// the pulse lands in the idle cycle that closes strobe_alone_s
	pw_pulse_a: assert property (strobe_alone_s |-> pulse_s) // [R1]
		else $error("pulse-width update is not a single cycle pulse");
	strap_load_a: assert property (strap_load && !i_cmd.valid |=> // [R2]
		cfg_reg.gain == loop_gain_pkg::strap_gain($past(strap_s3_reg)))
		else $error("gain not loaded from strap");
	integ_step_a: assert property (i_cycle_strobe |=> // [R3]
		integ_reg == $past(integ_reg) + $past(i_term))
		else $error("integral term did not accumulate");
	pw_sum_a: assert property (i_cycle_strobe |=> o_pw_correction == // [R4]
		sat16($past(p_term) + $past(integ_reg) + $past(i_term)
		- $past(r_term)))
		else $error("pulse-width sum wrong");
	resid_delay_a: assert property (strobe_gap_s |-> // [R5]
		resid_src_reg == $past(p_term, 2))
		else $error("residual source not one cycle behind");
	cfg_write_a: assert property (i_cmd.valid && i_cmd.write && // [R6]
		i_cmd.code == loop_gain_pkg::CMD_LOOP_GAIN_CONFIG |=>
		cfg_reg == $past(i_cmd.data))
		else $error("config command not stored");
	quiet_enter_a: assert property (state_reg == loop_gain_pkg::GS_QUIET && // [R7]
		quiet_cnt_reg == loop_gain_pkg::QUIET_CYCLES - 8'h01 &&
		i_cycle_strobe && err_low |=> state_reg == loop_gain_pkg::GS_REDUCED)
		else $error("reducer did not engage after quiet period");
	reduce_div_a: assert property (i_cycle_strobe && err_low && // [R8]
		state_reg == loop_gain_pkg::GS_REDUCED |=> o_applied_gain ==
		$past(cfg_reg.gain) >> ({1'b0, $past(red_reg.div_sel)} + 3'h1))
		else $error("reduced gain wrong");
	restore_full_a: assert property (i_cycle_strobe && !err_low |=> // [R9]
		o_applied_gain == $past(cfg_reg.gain) && !o_gain_reduced)
		else $error("full gain not restored at once");
	no_early_a: assert property (state_reg == loop_gain_pkg::GS_FULL |=> // [R10]
		state_reg != loop_gain_pkg::GS_REDUCED)
		else $error("gain reduced without quiet period");
endmodule
`default_nettype wire

//--- loop_gain_pkg.sv
// constants and types for the digital loop gain compensator
// Summary of operation
// [R1] pulse-width term is error scaled by the 16-bit gain in config bits 15:0
// [R2] gain field powers up from the decoded first configuration strap input
// [R3] 8-bit integral gain in config bits 31:24 drives the integral term
// [R4] 8-bit residual gain in bits 23:16 scales back the gain term's deviation
// [R5] residual correction lands one switching cycle after its gain correction
// [R6] apart from the strap gain default, loop parameters come only from the two configuration commands; reset sets integral gain 8'h10, residual gain 8'h20
// [R7] reducer compares error against 12-bit threshold in reduction bits 11:0
// [R8] while error stays low, gain is divided by code in reduction bits 13:12
// [R9] any cycle with error over threshold restores full gain at once
// [R10] quiet period length and divisor per code are fixed constants
package loop_gain_pkg;
	localparam logic [7:0] CMD_LOOP_GAIN_CONFIG = 8'hdf;
	localparam logic [7:0] CMD_LOOP_GAIN_REDUCTION_CONFIG = 8'hd5;
	localparam int GAIN_LSB = 0;
	localparam int RES_GAIN_LSB = 16;
	localparam int INT_GAIN_LSB = 24;
	localparam int THR_LSB = 0;
	localparam int DIV_SEL_LSB = 12;
	localparam logic [7:0] INT_GAIN_RST = 8'h10;
	localparam logic [7:0] RES_GAIN_RST = 8'h20;
	localparam logic [15:0] REDUCTION_CFG_RST = 16'h0000;
	localparam logic [7:0] QUIET_CYCLES = 8'h10;
	localparam int FRAC_SHIFT = 8;

	typedef struct packed {
		logic [7:0] int_gain;
		logic [7:0] res_gain;
		logic [15:0] gain;
	} loop_cfg_t;

	typedef struct packed {
		logic [1:0] rsvd;
		logic [1:0] div_sel;
		logic [11:0] thr;
	} reduce_cfg_t;

	typedef struct packed {
		logic valid;
		logic write;
		logic [7:0] code;
		logic [31:0] data;
	} cmd_t;

	typedef enum logic [2:0] {
		GS_FULL = 3'b001,
		GS_QUIET = 3'b010,
		GS_REDUCED = 3'b100
	} gain_state_t;

	// strap code to default gain; values are a plain ladder
	function automatic logic [15:0] strap_gain(input logic [2:0] code);
		strap_gain = {5'h00, code, 8'h00} + 16'h0080;
	endfunction
endpackage

//--- testbench.sv
// self-checking bench for the loop gain compensator
`timescale 1ns/1ns
`default_nettype none
module testbench;
	logic i_core_clk = 1'b0;
	logic i_rst = 1'b1;
	logic [2:0] i_first_config_strap = 3'h3;
	logic i_cycle_strobe = 1'b0;
	logic signed [15:0] i_error = 16'h0000;
	loop_gain_pkg::cmd_t i_cmd = '0;
	logic [31:0] o_rd_data;
	logic o_rd_valid;
	logic o_cmd_nack;
	logic signed [15:0] o_pw_correction;
	logic o_pw_valid;
	logic [15:0] o_applied_gain;
	logic o_gain_reduced;
	int n_errors = 0;
	int comparisons = 0;

	// 100 mhz clock
	always #5 i_core_clk = ~i_core_clk;

	loop_gain_ctrl loop_gain_ctrl_i (.i_core_clk(i_core_clk), .i_rst(i_rst),
		.i_first_config_strap(i_first_config_strap),
		.i_cycle_strobe(i_cycle_strobe), .i_error(i_error), .i_cmd(i_cmd),
		.o_rd_data(o_rd_data), .o_rd_valid(o_rd_valid),
		.o_cmd_nack(o_cmd_nack), .o_pw_correction(o_pw_correction),
		.o_pw_valid(o_pw_valid), .o_applied_gain(o_applied_gain),
		.o_gain_reduced(o_gain_reduced));

	////////////////////////////////////////////////////////////////////////
	task automatic end_of_test();
		$display("comparisons=%0d mismatches=%0d", comparisons, n_errors);
		if (n_errors == 0 && comparisons > 0)
			$display("[ PASS ]");
		else
			$display("[ FAIL ]");
		$finish;
	endtask

	task automatic check(input logic [31:0] seen, input logic [31:0] exp);
		comparisons++;
		if (seen !== exp) begin
			n_errors++;
			$display("[FAIL] t=%0t seen=%h exp=%h", $time, seen, exp);
		end
	endtask

	// one-cycle command; answer lands at the same edge that takes it
	task automatic cmd(input logic w, input logic [7:0] c,
		input logic [31:0] d);
		@(posedge i_core_clk);
		i_cmd <= loop_gain_pkg::cmd_t'({1'b1, w, c, d});
		@(posedge i_core_clk);
		i_cmd <= '0;
		#1;
	endtask

	task automatic rd(input logic [7:0] c, input logic [31:0] exp);
		cmd(1'b0, c, 32'h0000_0000);
		check({31'h0, o_rd_valid}, 32'h0000_0001);
		check({31'h0, o_cmd_nack}, 32'h0000_0000);
		check(o_rd_data, exp);
	endtask

	// strobe with one error sample, then look at the one-cycle answer
	task automatic strobe(input logic [15:0] e);
		@(posedge i_core_clk);
		i_cycle_strobe <= 1'b1;
		i_error <= e;
		@(posedge i_core_clk);
		i_cycle_strobe <= 1'b0;
		#1;
		check({31'h0, o_pw_valid}, 32'h0000_0001);
	endtask

	////////////////////////////////////////////////////////////////////////
	// reset values, strap default and refusal of foreign codes
	task automatic test_defaults();
		rd(8'hdf, {8'h10, 8'h20, 16'h0380});
		rd(8'hd5, 32'h0000_0000);
		cmd(1'b0, 8'hd0, 32'h0000_0000);
		check({31'h0, o_cmd_nack}, 32'h0000_0001);
		$display("test defaults done");
	endtask

	// gain term now, residual term one strobe later
	task automatic test_residual();
		cmd(1'b1, 8'hdf, {8'h00, 8'h80, 16'h0100});
		rd(8'hdf, {8'h00, 8'h80, 16'h0100});
		strobe(16'h0000);
		strobe(16'h0040);
		check({16'h0, o_pw_correction}, 32'h0000_0040);
		check({16'h0, o_applied_gain}, 32'h0000_0100);
		strobe(16'h0000);
		check({16'h0, o_pw_correction}, 32'h0000_ffe0);
		$display("test residual done");
	endtask

	// each divisor code: quiet run divides, threshold hit restores
	task automatic test_reducer();
		cmd(1'b1, 8'hdf, {8'h00, 8'h00, 16'h0100});
		for (int d = 0; d < 4; d++) begin
			cmd(1'b1, 8'hd5, {16'h0, 2'b11, 2'(d), 12'h100});
			rd(8'hd5, {16'h0, 2'b00, 2'(d), 12'h100});
			strobe(16'h0100);
			check({31'h0, o_gain_reduced}, 32'h0000_0000);
			for (int k = 0; k < 15; k++)
				strobe(16'hfffc);
			check({31'h0, o_gain_reduced}, 32'h0000_0000);
			strobe(16'h0004);
			strobe(16'h0004);
			check({31'h0, o_gain_reduced}, 32'h0000_0001);
			check({16'h0, o_applied_gain}, 32'(16'h0100 >> (d + 1)));
			strobe(16'h0100);
			check({31'h0, o_gain_reduced}, 32'h0000_0000);
			check({16'h0, o_applied_gain}, 32'h0000_0100);
			check({16'h0, o_pw_correction}, 32'h0000_0100);
		end
		$display("test reducer done");
	endtask

	// integrator accumulates across strobes with zero gain term
	task automatic test_integral();
		cmd(1'b1, 8'hd5, 32'h0000_0000);
		cmd(1'b1, 8'hdf, {8'h80, 8'h00, 16'h0000});
		strobe(16'h0040);
		check({16'h0, o_pw_correction}, 32'h0000_0020);
		strobe(16'h0040);
		check({16'h0, o_pw_correction}, 32'h0000_0040);
		$display("test integral done");
	endtask

	// mid-run reset: outputs clear and a new strap code is decoded
	task automatic test_reset_strap();
		@(posedge i_core_clk);
		i_first_config_strap <= 3'h5;
		i_rst <= 1'b1;
		repeat (4) @(posedge i_core_clk);
		#1;
		check({31'h0, o_pw_valid}, 32'h0000_0000);
		check({16'h0, o_pw_correction}, 32'h0000_0000);
		check({16'h0, o_applied_gain}, 32'h0000_0000);
		check({31'h0, o_gain_reduced}, 32'h0000_0000);
		@(posedge i_core_clk);
		i_rst <= 1'b0;
		repeat (2) @(posedge i_core_clk);
		rd(8'hdf, {8'h10, 8'h20, 16'h0580});
		rd(8'hd5, 32'h0000_0000);
		$display("test reset strap done");
	endtask

	////////////////////////////////////////////////////////////////////////
	// watchdog: the whole run needs well under 2000 cycles
	initial begin
		#100000;
		n_errors++;
		end_of_test();
	end

	// main sequence; strap is given time to pass its synchroniser
	initial begin
		repeat (6) @(posedge i_core_clk);
		i_rst <= 1'b0;
		repeat (10) @(posedge i_core_clk);
		test_defaults();
		test_residual();
		test_reducer();
		test_integral();
		test_reset_strap();
		end_of_test();
	end
endmodule
`default_nettype wire
